// ===== src/nce_pkg.sv
// constants for the nibble cpu instruction executor
package nce_pkg;
    localparam int          PC_W          = 12;
    localparam int          TGT_W         = 11;
    localparam int          STACK_DEPTH   = 4;
    localparam int          BANK_W        = 3;
    localparam int          ADDR_W        = 7;
    localparam int          WARMUP_DIV    = 512;
    localparam int          CYC_FAST      = 4;
    localparam int          CYC_SLOW      = 16;
    localparam int          DAA_LIMIT     = 9;
    localparam logic [3:0]  DEC_SIX       = 4'h6;
    localparam logic [3:0]  DEC_TEN       = 4'hA;
    localparam logic [PC_W-1:0] PC_RESET  = 12'h000;
    // opcode prefixes (top five bits)
    localparam logic [4:0]  OP_ADC        = 5'h00;
    localparam logic [4:0]  OP_ADD        = 5'h01;
    localparam logic [4:0]  OP_SBC        = 5'h02;
    localparam logic [4:0]  OP_SUB        = 5'h03;
    localparam logic [4:0]  OP_XOR        = 5'h04;
    localparam logic [4:0]  OP_OR         = 5'h05;
    localparam logic [4:0]  OP_AND        = 5'h06;
    localparam logic [4:0]  OP_LDST       = 5'h07;
    localparam logic [4:0]  OP_ADI        = 5'h08;
    localparam logic [4:0]  OP_IMMEDIATE_SUM_WRITEBACK       = 5'h09;
    localparam logic [4:0]  OP_SBI        = 5'h0A;
    localparam logic [4:0]  OP_IMMEDIATE_DIFFERENCE_WRITEBACK       = 5'h0B;
    localparam logic [4:0]  OP_XORI       = 5'h0C;
    localparam logic [4:0]  OP_ORI        = 5'h0D;
    localparam logic [4:0]  OP_ANDI       = 5'h0E;
    localparam logic [4:0]  OP_LDI        = 5'h0F;
    localparam logic [4:0]  OP_BNZ        = 5'h10;
    localparam logic [4:0]  OP_BNC        = 5'h11;
    localparam logic [4:0]  OP_BAZ        = 5'h12;
    localparam logic [4:0]  OP_BC         = 5'h13;
    localparam logic [4:0]  OP_CALL       = 5'h18;
    localparam logic [4:0]  OP_DEC        = 5'h19;
    localparam logic [4:0]  OP_RET        = 5'h1A;
    localparam logic [4:0]  OP_PWR        = 5'h1B;
    localparam logic [3:0]  OP_JMP4       = 4'hE;
    localparam logic [3:0]  DEC_ADD_SEL   = 4'h6;
    localparam logic [3:0]  DEC_SUB_SEL   = 4'hA;
    localparam logic [15:0] W_SHR         = 16'hF000;
    localparam logic [15:0] W_TABLE_INDEXED_JUMP        = 16'hF7FF;
    localparam logic [15:0] W_NOP         = 16'hFFFF;
    localparam logic [15:0] W_RETI        = 16'hD400;
    localparam logic [15:0] W_HALT        = 16'hD800;
    localparam logic [15:0] W_STOP        = 16'hDC00;
    typedef enum logic [1:0] {
        NCE_WARM = 2'b00,
        NCE_RUN  = 2'b01,
        NCE_HALT = 2'b11,
        NCE_STOP = 2'b10
    } nce_state_type;
endpackage : nce_pkg

// ===== src/nce_cycle_timer.sv
// programmable divider: pulses once every last_in + 1 clocks while enabled
`timescale 1ns/1ns
module nce_cycle_timer #(
    parameter int W = 9
) (
    input  wire logic         ref_clk_in,
    input  wire logic         rst_in,
    input  wire logic         run_in,
    input  wire logic [W-1:0] last_in,
    output logic              tick_out
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    wire          at_end = (cnt_q == last_in);

    assign cnt_d    = (!run_in || at_end) ? '0 : cnt_q + W'(1);
    assign tick_out = run_in && at_end;

    always_ff @(posedge ref_clk_in or posedge rst_in)
        if (rst_in)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
endmodule : nce_cycle_timer

// ===== src/nce_alu.sv
// 4-bit adder/logic unit with decimal adjust
`timescale 1ns/1ns
module nce_alu (
    input  wire logic [2:0] sel_in,
    input  wire logic [3:0] a_in,
    input  wire logic [3:0] b_in,
    input  wire logic       cin_in,
    output logic [3:0]      res_out,
    output logic            cout_out
);
    // sel: 0 add, 1 xor, 2 or, 3 and, 4 decimal add fix, 5 decimal sub fix
    wire [4:0] sum    = {1'b0, a_in} + {1'b0, b_in} + {4'h0, cin_in};
    wire       da_hi  = cin_in || (a_in > 4'(nce_pkg::DAA_LIMIT));
    wire [4:0] da_sum = {1'b0, a_in} + {1'b0, nce_pkg::DEC_SIX};
    wire [3:0] ds_fix = a_in + nce_pkg::DEC_TEN;

    always_comb
    begin
        res_out  = sum[3:0];
        cout_out = sum[4];
        case (sel_in)
            3'h1: begin res_out = a_in ^ b_in; cout_out = cin_in; end
            3'h2: begin res_out = a_in | b_in; cout_out = cin_in; end
            3'h3: begin res_out = a_in & b_in; cout_out = cin_in; end
            3'h4:
            begin
                res_out  = da_hi ? da_sum[3:0] : a_in;
                cout_out = da_hi;
            end
            3'h5:
            begin
                // borrow pending when carry clear after subtract
                res_out  = cin_in ? a_in : ds_fix;
                cout_out = cin_in;
            end
            default: ;
        endcase
    end
endmodule : nce_alu

// ===== src/nce_core.sv
// instruction decode and execute for the 4-bit core
// Function
// [RULE1] one word, one instruction cycle each
// [RULE2] add with/without carry, optional writeback
// [RULE3] subtract with borrow or plus one
// [RULE4] xor/or/and memory with work, carry kept
// [RULE5] shift work right, bit0 into carry
// [RULE6] immediate add, optional writeback, carry updated
// [RULE7] immediate subtract, optional writeback, carry updated
// [RULE8] immediate logic into work and memory
// [RULE9] decimal adjust after add or subtract
// [RULE10] load or store with bank select
// [RULE11] immediate load into work and memory
// [RULE12] branch on work zero/nonzero, carry
// [RULE13] branch on selected work bit set
// [RULE14] call pushes carry and pc, keeps page
// [RULE15] return loads table register and work
// [RULE16] return from interrupt restores carry, pc
// [RULE17] jump loads full twelve-bit target
// [RULE18] table jump and no operation
// [RULE19] halt stops cpu, any interrupt wakes
// [RULE20] stop halts all, port interrupt wakes
// [RULE21] warm-up of 512 clocks after reset/stop
// [RULE22] cycle length option 4 or 16 clocks
`timescale 1ns/1ns
module nce_core #(
    parameter bit SLOW_CYCLE = 1'b0,
    parameter int WARMUP     = nce_pkg::WARMUP_DIV
) (
    input  wire logic                        ref_clk_in,
    input  wire logic                        rst_in,
    input  wire logic [15:0]                 rom_data_in,
    input  wire logic [3:0]                  mem_rdata_in,
    input  wire logic                        irq_any_in,
    input  wire logic                        irq_port_in,
    output logic [nce_pkg::PC_W-1:0]         rom_addr_out,
    output logic [nce_pkg::BANK_W-1:0]       mem_bank_out,
    output logic [nce_pkg::ADDR_W-1:0]       mem_addr_out,
    output logic [3:0]                       mem_wdata_out,
    output logic                             mem_we_out,
    output logic                             osc_stop_out,
    output logic                             cpu_halted_out,
    output logic                             cycle_done_out,
    output logic [3:0]                       work_register_out,
    output logic                             carry_flag_out
);
    // the warm-up divider is nine bits wide
    if (WARMUP < 1 || WARMUP > nce_pkg::WARMUP_DIV)
    begin : g_warm_check
        $error("warm-up count out of range");
    end

    localparam int PW = nce_pkg::PC_W;

    nce_pkg::nce_state_type state_q;
    nce_pkg::nce_state_type state_d;
    logic [PW-1:0]  pc_q;
    logic [PW-1:0]  pc_d;
    logic [3:0]     work_register_q;
    logic [3:0]     work_d;
    logic           carry_flag_q;
    logic           carry_d;
    logic [3:0]     table_branch_reg_q;
    logic [3:0]     tbr_d;
    logic [PW:0]    stack_q [nce_pkg::STACK_DEPTH];
    logic [1:0]     sp_q;
    logic [1:0]     sp_d;
    logic           push;
    logic           pop;
    logic [1:0]     irq_any_s;
    logic [1:0]     irq_port_s;

    // pins are asynchronous to the core clock
    always_ff @(posedge ref_clk_in or posedge rst_in)
        if (rst_in)
        begin
            irq_any_s  <= 2'b00;
            irq_port_s <= 2'b00;
        end
        else
        begin
            irq_any_s  <= {irq_any_s[0], irq_any_in};
            irq_port_s <= {irq_port_s[0], irq_port_in};
        end
    wire irq_any  = irq_any_s[1];
    wire irq_port = irq_port_s[1];

    // instruction cycle and warm-up dividers
    wire       cyc_run = (state_q == nce_pkg::NCE_RUN);
    wire       warm_run = (state_q == nce_pkg::NCE_WARM);
    wire [3:0] cyc_last = SLOW_CYCLE ? 4'(nce_pkg::CYC_SLOW - 1) : 4'(nce_pkg::CYC_FAST - 1); // [RULE22]
    wire [8:0] warm_last = 9'(WARMUP - 1);
    wire       exec;
    wire       warm_done;

    nce_cycle_timer #(.W(4)) u_cyc (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .run_in     (cyc_run),
        .last_in    (cyc_last),
        .tick_out   (exec)
    );
    nce_cycle_timer #(.W(9)) u_warm (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .run_in     (warm_run),
        .last_in    (warm_last),
        .tick_out   (warm_done)
    );

    // decode
    wire [15:0] ir      = rom_data_in;
    wire [4:0]  op      = ir[15:11];
    wire        wb_bit  = ir[10];
    wire [3:0]  imm     = ir[10:7];
    wire [6:0]  maddr   = ir[6:0];
    wire [10:0] tgt     = ir[10:0];
    wire        is_arith = (op <= nce_pkg::OP_AND);                     // [RULE2] [RULE3] [RULE4]
    wire        is_imm   = (op >= nce_pkg::OP_ADI) && (op <= nce_pkg::OP_ANDI);
    wire        is_dec   = (op == nce_pkg::OP_DEC)
                           && (ir[10:7] == nce_pkg::DEC_ADD_SEL || ir[10:7] == nce_pkg::DEC_SUB_SEL);
    wire        is_ldst  = (op == nce_pkg::OP_LDST);
    wire        is_ldi   = (op == nce_pkg::OP_LDI);
    wire        is_br    = (op[4:3] == 2'b10);
    wire        is_call  = (op == nce_pkg::OP_CALL);
    wire        is_retw  = (op == nce_pkg::OP_RET) && (ir[10:8] == 3'b000);
    wire        is_reti  = (ir == nce_pkg::W_RETI);
    wire        is_jmp   = (ir[15:12] == nce_pkg::OP_JMP4);
    wire        is_shr   = (ir == nce_pkg::W_SHR);
    wire        is_table_indexed_jump  = (ir == nce_pkg::W_TABLE_INDEXED_JUMP);
    wire        is_halt  = (ir == nce_pkg::W_HALT);
    wire        is_stop  = (ir == nce_pkg::W_STOP);

    // branch condition
    logic br_take;
    always_comb
    begin
        case (op)
            nce_pkg::OP_BAZ: br_take = (work_register_q == 4'h0);        // [RULE12]
            nce_pkg::OP_BNZ: br_take = (work_register_q != 4'h0);
            nce_pkg::OP_BC:  br_take = carry_flag_q;
            nce_pkg::OP_BNC: br_take = !carry_flag_q;
            default:         br_take = work_register_q[op[1:0]];        // [RULE13]
        endcase
    end

    // alu operand steering
    wire [2:0] alu_sel = is_dec ? (ir[10:7] == nce_pkg::DEC_ADD_SEL ? 3'h4 : 3'h5)
                       : is_arith ? ((op[2:1] == 2'b00 || op == nce_pkg::OP_SBC || op == nce_pkg::OP_SUB)
                                     ? 3'h0 : {1'b0, op[1:0] + 2'b01} - 3'h0)
                       : (op[2:1] == 2'b00 || op == nce_pkg::OP_SBI || op == nce_pkg::OP_IMMEDIATE_DIFFERENCE_WRITEBACK)
                         ? 3'h0 : {1'b0, op[1:0] + 2'b01};
    wire       sub_op  = is_arith ? (op == nce_pkg::OP_SBC || op == nce_pkg::OP_SUB)     // [RULE3]
                                  : (op == nce_pkg::OP_SBI || op == nce_pkg::OP_IMMEDIATE_DIFFERENCE_WRITEBACK);   // [RULE7]
    wire [3:0] src_b   = is_arith ? work_register_q : imm;
    wire [3:0] alu_b   = sub_op ? ~src_b : src_b;
    wire       alu_cin = is_dec ? carry_flag_q
                       : (op == nce_pkg::OP_ADC || op == nce_pkg::OP_SBC) ? carry_flag_q
                       : (op == nce_pkg::OP_SUB || op == nce_pkg::OP_SBI || op == nce_pkg::OP_IMMEDIATE_DIFFERENCE_WRITEBACK);
    wire [3:0] alu_res;
    wire       alu_cout;
    wire       keeps_carry = alu_sel[2:1] == 2'b00 ? alu_sel[0] : (alu_sel == 3'h2 || alu_sel == 3'h3);

    nce_alu u_alu (
        .sel_in   (alu_sel),
        .a_in     (mem_rdata_in),
        .b_in     (alu_b),
        .cin_in   (alu_cin),
        .res_out  (alu_res),
        .cout_out (alu_cout)
    );

    // writeback to memory
    wire mem_wr = is_arith ? wb_bit                                     // [RULE2] [RULE3] [RULE4]
                : is_imm ? (op != nce_pkg::OP_ADI && op != nce_pkg::OP_SBI) // [RULE6] [RULE7] [RULE8]
                : is_dec || is_ldi || (is_ldst && wb_bit);              // [RULE9] [RULE10] [RULE11]

    assign rom_addr_out  = pc_q;
    assign mem_bank_out  = (is_arith || is_ldst) ? ir[9:7] : 3'h0;      // [RULE10]
    assign mem_addr_out  = maddr;
    assign mem_wdata_out = is_ldi ? imm : (is_ldst ? work_register_q : alu_res);
    assign mem_we_out    = exec && mem_wr;                             // [RULE1]

    wire [PW-1:0] pc_inc = pc_q + PW'(1);
    wire [PW:0]   stack_top = stack_q[sp_q - 2'd1];

    // next-state: everything commits on the single exec pulse
    always_comb
    begin
        pc_d    = pc_inc;
        work_d  = work_register_q;
        carry_d = carry_flag_q;
        tbr_d   = table_branch_reg_q;
        push    = 1'b0;
        pop     = 1'b0;
        if (is_arith || is_imm || is_dec)
        begin
            work_d  = alu_res;
            carry_d = keeps_carry ? carry_flag_q : alu_cout;            // [RULE4] [RULE8] [RULE9]
        end
        else if (is_ldst)
            work_d = wb_bit ? work_register_q : mem_rdata_in;           // [RULE10]
        else if (is_ldi)
            work_d = imm;                                                // [RULE11]
        else if (is_br)
            pc_d = br_take ? {pc_q[PW-1], tgt} : pc_inc;                // [RULE12] [RULE13]
        else if (is_call)
        begin
            push = 1'b1;                                                 // [RULE14]
            pc_d = {pc_q[PW-1], tgt};
        end
        else if (is_retw)
        begin
            pop    = 1'b1;                                               // [RULE15]
            pc_d   = stack_top[PW-1:0];
            tbr_d  = ir[7:4];
            work_d = ir[3:0];
        end
        else if (is_reti)
        begin
            pop     = 1'b1;                                              // [RULE16]
            pc_d    = stack_top[PW-1:0];
            carry_d = stack_top[PW];
        end
        else if (is_jmp)
            pc_d = ir[PW-1:0];                                           // [RULE17]
        else if (is_shr)
        begin
            work_d  = {1'b0, work_register_q[3:1]};                      // [RULE5]
            carry_d = work_register_q[0];
        end
        else if (is_table_indexed_jump)
            pc_d = {pc_q[11:8], table_branch_reg_q, work_register_q};   // [RULE18]
    end

    assign sp_d = push ? sp_q + 2'd1 : (pop ? sp_q - 2'd1 : sp_q);

    // power state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            nce_pkg::NCE_WARM: if (warm_done) state_d = nce_pkg::NCE_RUN;          // [RULE21]
            nce_pkg::NCE_RUN:
            begin
                if (exec && is_halt) state_d = nce_pkg::NCE_HALT;                  // [RULE19]
                if (exec && is_stop) state_d = nce_pkg::NCE_STOP;                  // [RULE20]
            end
            nce_pkg::NCE_HALT: if (irq_any || irq_port) state_d = nce_pkg::NCE_RUN; // [RULE19]
            nce_pkg::NCE_STOP: if (irq_port) state_d = nce_pkg::NCE_WARM;          // [RULE20] [RULE21]
            default: state_d = nce_pkg::NCE_WARM;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
        if (rst_in)
        begin
            state_q            <= nce_pkg::NCE_WARM;
            pc_q               <= nce_pkg::PC_RESET;
            work_register_q    <= 4'h0;
            carry_flag_q       <= 1'b0;
            table_branch_reg_q <= 4'h0;
            sp_q               <= 2'd0;
        end
        else
        begin
            state_q <= state_d;
            if (exec)
            begin
                pc_q               <= pc_d;
                work_register_q    <= work_d;
                carry_flag_q       <= carry_d;
                table_branch_reg_q <= tbr_d;
                sp_q               <= sp_d;
            end
        end

    // stack holds carry with return address; overflow wraps silently, oldest entry lost
    always_ff @(posedge ref_clk_in)
        if (exec && push)
            stack_q[sp_q] <= {carry_flag_q, pc_inc};                     // [RULE14]

    assign osc_stop_out      = (state_q == nce_pkg::NCE_STOP);
    assign cpu_halted_out    = (state_q != nce_pkg::NCE_RUN);
    assign cycle_done_out    = exec;
    assign work_register_out = work_register_q;
    assign carry_flag_out    = carry_flag_q;

    // assertions
    property p_shr;
        @(posedge ref_clk_in) disable iff (rst_in)
        exec && is_shr |=> work_register_q == {1'b0, $past(work_register_q[3:1])}
                           && carry_flag_q == $past(work_register_q[0]);
    endproperty
    a_shr: assert property (p_shr) else $error("shift right wrong"); // [RULE5]

    property p_logic_carry;
        @(posedge ref_clk_in) disable iff (rst_in)
        exec && (is_arith && op >= nce_pkg::OP_XOR || op >= nce_pkg::OP_XORI && op <= nce_pkg::OP_LDI)
        |=> $stable(carry_flag_q);
    endproperty
    a_logic_carry: assert property (p_logic_carry) else $error("logic op changed carry"); // [RULE4]

    property p_imm_we;
        @(posedge ref_clk_in) disable iff (rst_in)
        exec && (op == nce_pkg::OP_ADI || op == nce_pkg::OP_SBI) |-> !mem_we_out;
    endproperty
    a_imm_we: assert property (p_imm_we) else $error("immediate op wrote memory"); // [RULE6]

    property p_ldi;
        @(posedge ref_clk_in) disable iff (rst_in)
        exec && is_ldi |-> mem_we_out && mem_wdata_out == imm ##1 work_register_q == $past(imm);
    endproperty
    a_ldi: assert property (p_ldi) else $error("immediate load wrong"); // [RULE11]

    property p_jmp;
        @(posedge ref_clk_in) disable iff (rst_in)
        exec && is_jmp |=> pc_q == $past(ir[11:0]);
    endproperty
    a_jmp: assert property (p_jmp) else $error("jump target wrong"); // [RULE17]

    property p_call_page;
        @(posedge ref_clk_in) disable iff (rst_in)
        exec && is_call |=> pc_q[11] == $past(pc_q[11]) && pc_q[10:0] == $past(tgt);
    endproperty
    a_call_page: assert property (p_call_page) else $error("call changed page"); // [RULE14]

    property p_one_cycle;
        @(posedge ref_clk_in) disable iff (rst_in)
        exec |=> !exec [*3];
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("cycle shorter than four clocks"); // [RULE22]

    property p_halt;
        @(posedge ref_clk_in) disable iff (rst_in)
        exec && is_halt |=> state_q == nce_pkg::NCE_HALT;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not entered"); // [RULE19]

    property p_stop_warm;
        @(posedge ref_clk_in) disable iff (rst_in)
        state_q == nce_pkg::NCE_STOP && irq_port |=> state_q == nce_pkg::NCE_WARM;
    endproperty
    a_stop_warm: assert property (p_stop_warm) else $error("stop wake skipped warm-up"); // [RULE20]
endmodule : nce_core

// ===== tb/tb_top.sv
// self-checking bench for the nibble core executor
`timescale 1ns/1ns
module tb_top;
    localparam int WARM = 8;
    logic                       ref_clk_in;
    logic                       rst_in;
    logic [15:0]                rom_data_in;
    logic [3:0]                 mem_rdata_in;
    logic                       irq_any_in;
    logic                       irq_port_in;
    logic [nce_pkg::PC_W-1:0]   rom_addr_out;
    logic [nce_pkg::BANK_W-1:0] mem_bank_out;
    logic [nce_pkg::ADDR_W-1:0] mem_addr_out;
    logic [3:0]                 mem_wdata_out;
    logic                       mem_we_out;
    logic                       osc_stop_out;
    logic                       cpu_halted_out;
    logic                       cycle_done_out;
    logic [3:0]                 work_register_out;
    logic                       carry_flag_out;
    logic                       slow_done;
    logic [3:0]                 mem [0:1023];
    int                         err_total;
    int                         tests_run;
    int                         last_n;

    nce_core #(.WARMUP(WARM)) DUT (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .rom_data_in(rom_data_in), .mem_rdata_in(mem_rdata_in),
        .irq_any_in(irq_any_in), .irq_port_in(irq_port_in), .rom_addr_out(rom_addr_out),
        .mem_bank_out(mem_bank_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
        .mem_we_out(mem_we_out), .osc_stop_out(osc_stop_out), .cpu_halted_out(cpu_halted_out),
        .cycle_done_out(cycle_done_out), .work_register_out(work_register_out), .carry_flag_out(carry_flag_out)
    );
    // second core only times the long cycle option, its data path is not judged
    nce_core #(.SLOW_CYCLE(1'b1), .WARMUP(WARM)) DUT_SLOW (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .rom_data_in(rom_data_in), .mem_rdata_in(4'h0),
        .irq_any_in(irq_any_in), .irq_port_in(irq_port_in), .rom_addr_out(), .mem_bank_out(),
        .mem_addr_out(), .mem_wdata_out(), .mem_we_out(), .osc_stop_out(), .cpu_halted_out(),
        .cycle_done_out(slow_done), .work_register_out(), .carry_flag_out()
    );

    // data memory reads back combinationally, as the core expects
    assign mem_rdata_in = mem[{mem_bank_out, mem_addr_out}];
    always @(posedge ref_clk_in)
        if (mem_we_out === 1'b1) mem[{mem_bank_out, mem_addr_out}] <= mem_wdata_out;

    initial
    begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict;
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // counts falling edges up to the next commit pulse of the core picked by slow
    task automatic wdone(input bit slow);
        last_n = 0;
        do
        begin
            @(negedge ref_clk_in);
            last_n++;
        end
        while (((slow ? slow_done : cycle_done_out) !== 1'b1) && last_n < 400);
        if (last_n >= 400) chk(16'h0, 16'h1);
    endtask : wdone

    // carry expectation 2 means not judged
    task automatic ex(input logic [15:0] wd, input logic [3:0] ew, input logic [1:0] ec,
                      input logic [3:0] em, input logic [11:0] ep);
        @(posedge ref_clk_in);
        rom_data_in <= wd;
        wdone(1'b0);
        @(posedge ref_clk_in);
        #1;
        chk(16'(work_register_out), 16'(ew));
        if (ec != 2'h2) chk(16'(carry_flag_out), 16'(ec[0]));
        chk(16'(mem[5]), 16'(em));
        chk(16'(rom_addr_out), 16'(ep));
    endtask : ex

    task automatic do_reset;
        @(posedge ref_clk_in);
        rst_in <= 1'b1;
        repeat (10) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(negedge ref_clk_in);
        chk(16'(cpu_halted_out), 16'h1);
    endtask : do_reset

    task automatic t_cycle;
        wdone(1'b0);
        wdone(1'b0);
        chk(16'(last_n), 16'(nce_pkg::CYC_FAST));
        wdone(1'b1);
        wdone(1'b1);
        chk(16'(last_n), 16'(nce_pkg::CYC_SLOW));
    endtask : t_cycle

    task automatic t_exec;
        ex(16'h7C85, 4'h9, 2'h0, 4'h9, 12'h001);
        chk(16'(last_n >= WARM), 16'h1);
        ex(16'h0805, 4'h2, 2'h1, 4'h9, 12'h002);
        ex(16'h2805, 4'hB, 2'h1, 4'h9, 12'h003);
        ex(16'h0405, 4'h5, 2'h1, 4'h5, 12'h004);
        ex(16'h3405, 4'h5, 2'h1, 4'h5, 12'h005);
        ex(16'h2005, 4'h0, 2'h1, 4'h5, 12'h006);
        ex(16'h1005, 4'h5, 2'h1, 4'h5, 12'h007);
        ex(16'h1C05, 4'h0, 2'h1, 4'h0, 12'h008);
        ex(16'h4B85, 4'h7, 2'h0, 4'h7, 12'h009);
        ex(16'h4505, 4'h1, 2'h1, 4'h7, 12'h00A);
        ex(16'h5C05, 4'hF, 2'h0, 4'hF, 12'h00B);
        ex(16'h5785, 4'h0, 2'h1, 4'hF, 12'h00C);
        ex(16'h7185, 4'h3, 2'h1, 4'h3, 12'h00D);
        ex(16'h6C05, 4'hB, 2'h1, 4'hB, 12'h00E);
        ex(16'h6305, 4'hD, 2'h1, 4'hD, 12'h00F);
        ex(16'hF000, 4'h6, 2'h1, 4'hD, 12'h010);
        ex(16'hF000, 4'h3, 2'h0, 4'hD, 12'h011);
        ex(16'h3805, 4'hD, 2'h0, 4'hD, 12'h012);
        ex(16'hCB05, 4'h3, 2'h1, 4'h3, 12'h013);
        ex(16'h7A05, 4'h4, 2'h1, 4'h4, 12'h014);
        ex(16'h5A85, 4'hF, 2'h0, 4'hF, 12'h015);
        ex(16'hCD05, 4'h9, 2'h2, 4'h9, 12'h016);
        ex(16'h3D85, 4'h9, 2'h2, 4'h9, 12'h017);
        chk(16'(mem[{3'h3, 7'h05}]), 16'h9);
        ex(16'h9100, 4'h9, 2'h2, 4'h9, 12'h018);
        ex(16'h8100, 4'h9, 2'h2, 4'h9, 12'h100);
        ex(16'hF000, 4'h4, 2'h1, 4'h9, 12'h101);
        ex(16'h8A00, 4'h4, 2'h1, 4'h9, 12'h102);
        ex(16'h9A00, 4'h4, 2'h1, 4'h9, 12'h200);
        ex(16'hA300, 4'h4, 2'h1, 4'h9, 12'h201);
        ex(16'hB300, 4'h4, 2'h1, 4'h9, 12'h300);
        ex(16'hB880, 4'h4, 2'h1, 4'h9, 12'h301);
        ex(16'hE923, 4'h4, 2'h1, 4'h9, 12'h923);
        ex(16'hC045, 4'h4, 2'h1, 4'h9, 12'h845);
        ex(16'hF000, 4'h2, 2'h0, 4'h9, 12'h846);
        ex(16'hD400, 4'h2, 2'h1, 4'h9, 12'h924);
        ex(16'hC010, 4'h2, 2'h1, 4'h9, 12'h810);
        ex(16'hD057, 4'h7, 2'h1, 4'h9, 12'h925);
        ex(16'hF7FF, 4'h7, 2'h1, 4'h9, 12'h957);
        ex(16'hFFFF, 4'h7, 2'h1, 4'h9, 12'h958);
        // work bit 1 set: branch lands on its own page, pc unchanged
        ex(16'hA958, 4'h7, 2'h1, 4'h9, 12'h958);
    endtask : t_exec

    task automatic t_low_power;
        ex(16'hD800, 4'h7, 2'h1, 4'h9, 12'h959);
        @(posedge ref_clk_in);
        rom_data_in <= 16'hFFFF;
        repeat (24) @(negedge ref_clk_in) chk(16'(cycle_done_out), 16'h0);
        chk(16'({cpu_halted_out, osc_stop_out}), 16'h2);
        @(posedge ref_clk_in);
        irq_any_in <= 1'b1;
        ex(16'hFFFF, 4'h7, 2'h1, 4'h9, 12'h95A);
        // general interrupt stays pending: it must not end the stop
        ex(16'hDC00, 4'h7, 2'h1, 4'h9, 12'h95B);
        @(posedge ref_clk_in);
        rom_data_in <= 16'hFFFF;
        repeat (24) @(negedge ref_clk_in) chk(16'({osc_stop_out, cycle_done_out}), 16'h2);
        @(posedge ref_clk_in);
        irq_port_in <= 1'b1;
        irq_any_in <= 1'b0;
        wdone(1'b0);
        chk(16'(last_n >= WARM), 16'h1);
        chk(16'(osc_stop_out), 16'h0);
        @(posedge ref_clk_in);
        irq_port_in <= 1'b0;
        #1;
        chk(16'(rom_addr_out), 16'h95C);
    endtask : t_low_power

    initial
    begin
        repeat (6000) @(posedge ref_clk_in);
        err_total++;
        print_verdict();
    end

    initial
    begin
        rst_in = 1'b1;
        rom_data_in = 16'hFFFF;
        irq_any_in = 1'b0;
        irq_port_in = 1'b0;
        err_total = 0;
        tests_run = 0;
        for (int i = 0; i < 1024; i++) mem[i] = 4'h0;
        do_reset();
        t_cycle();
        do_reset();
        t_exec();
        t_low_power();
        print_verdict();
    end
endmodule : tb_top
